// file: shared/addr_table_pkg.sv
// constants for the address table access engine
package addr_table_pkg;

  // ----------------------------------------
  // register map (word addresses on the register port)
  // ----------------------------------------
  localparam logic [9:0] OFS_CMD_ADDR_LOW = 10'h11A;
  localparam logic [9:0] OFS_CMD_ADDR_MID = 10'h11B;
  localparam logic [9:0] OFS_CMD_ADDR_HIGH = 10'h11C;
  localparam logic [9:0] OFS_CMD_PORTS_GROUP = 10'h11D;
  localparam logic [9:0] OFS_CMD_ATTRIBUTES = 10'h11E;
  localparam logic [9:0] OFS_CMD_OPCODE = 10'h11F;
  localparam logic [9:0] OFS_RES_ADDR_LOW = 10'h120;
  localparam logic [9:0] OFS_RES_ADDR_MID = 10'h121;
  localparam logic [9:0] OFS_RES_ADDR_HIGH = 10'h122;
  localparam logic [9:0] OFS_RES_PORTS_GROUP = 10'h123;
  localparam logic [9:0] OFS_RES_ATTRIBUTES = 10'h124;
  localparam logic [9:0] OFS_RES_OUTCOME = 10'h125;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CMD_HI = 6;
  localparam int CMD_LO = 4;
  localparam int ACC_HI = 3;
  localparam int ACC_LO = 0;
  localparam int STATIC_BIT = 12;
  localparam int ATTR_HI = 8;
  localparam int PMAP_HI = 9;
  localparam int PMAP_LO = 4;
  localparam int GROUP_HI = 3;
  localparam int BUSY_BIT = 15;
  localparam int RES_HI = 14;
  localparam int RES_LO = 12;
  localparam int BAD_BIT = 2;
  localparam int OCC_BIT = 1;
  localparam int TYPE_BIT = 0;

  // ----------------------------------------
  // table geometry
  // ----------------------------------------
  localparam int HASH_BITS = 6;
  localparam int WAYS = 4;
  localparam int IDX_BITS = 8;
  localparam int ENTRIES = 256;
  localparam logic [7:0] LAST_IDX = 8'hFF;
  localparam logic [7:0] FIRST_IDX = 8'h00;

  // ----------------------------------------
  // commands, access codes, outcomes
  // ----------------------------------------
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_ERASE = 3'h1;
  localparam logic [2:0] CMD_SEARCH = 3'h2;
  localparam logic [2:0] CMD_POINTER = 3'h3;
  localparam logic [3:0] ACC_CREATE = 4'h7;
  localparam logic [3:0] ACC_EXACT = 4'hF;
  localparam logic [3:0] ACC_EMPTY = 4'h0;
  localparam logic [3:0] ACC_BY_ADDR = 4'h4;
  localparam logic [3:0] ACC_FIRST = 4'h0;
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_FULL = 3'h1;
  localparam logic [2:0] RES_NOT_FOUND = 3'h2;
  localparam logic [2:0] RES_CMD_ERROR = 3'h5;

  typedef enum logic [1:0] {st_idle, st_exec, st_scan} engine_state_t;

endpackage

// file: hw/address_table_access_engine.sv
// address table access engine: host command registers, 4-way hashed table, searches
`timescale 1ns/1ps

// Notes on behaviour
// [RQ1] command word five: command 6:4, access 3:0; static, attributes, ports, group fields
// [RQ2] 48-bit address is words two, one, zero, low word first
// [RQ3] command 000: access 0111 creates, access 1111 overwrites a matching entry
// [RQ4] command 001 access 1111 erases the matching entry
// [RQ5] command 010 access 0000 searches for an unoccupied location
// [RQ6] qualified search by port 1001, group 1010, address 1100, group+port 1011
// [RQ7] search address+group 1110, address+port 1101, all three 1111
// [RQ8] command 011 access 0100 sets search pointer to the address's hash location
// [RQ9] command 011 access 0000 resets search pointer to the first location
// [RQ10] successful search returns address, group, ports, attributes, static, valid, bad
// [RQ11] host ignores returned address when search did not succeed
// [RQ12] three-bit result: 000 success, 101 command error
// [RQ13] create fails with 001 when all four ways hold static entries
// [RQ14] table is 4-way hashed, four addresses per hash location
// [RQ15] busy reads 1 while working and new commands are refused
// [RQ16] host waits for busy low before loading operands
// [RQ17] host writes operand words first, command word last to launch
// [RQ18] host polls busy before reading results
// [RQ19] host initialises pointer before a new search sequence
// [RQ20] search scans top to bottom, pointer moves to the matched location
// [RQ21] host repeats the search until not found
// [RQ22] static entries never age; attribute field holds control bits
// [RQ23] result 010 means no entry found
// [RQ24] writing word five sets busy at once; busy clears with results stable
// [RQ25] unlisted combinations leave the table alone and return command error
module address_table_access_engine (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic engine_busy
);

  // ----------------------------------------
  // command registers
  // ----------------------------------------
  logic [15:0] cmd_addr_low;
  logic [15:0] cmd_addr_mid;
  logic [15:0] cmd_addr_high;
  logic [15:0] cmd_ports_group;
  logic [15:0] cmd_attributes;
  logic [15:0] cmd_opcode;
  addr_table_pkg::engine_state_t state;
  logic launch;

  // operands are frozen while busy so a running scan cannot see them change
  assign launch = reg_wr && (state == addr_table_pkg::st_idle)
    && (reg_addr == addr_table_pkg::OFS_CMD_OPCODE);

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_addr_low <= addr_table_pkg::WORD_RESET;
      cmd_addr_mid <= addr_table_pkg::WORD_RESET;
      cmd_addr_high <= addr_table_pkg::WORD_RESET;
      cmd_ports_group <= addr_table_pkg::WORD_RESET;
      cmd_attributes <= addr_table_pkg::WORD_RESET;
      cmd_opcode <= addr_table_pkg::WORD_RESET;
    end else if (reg_wr && state == addr_table_pkg::st_idle) begin // [RQ15]
      if (reg_addr == addr_table_pkg::OFS_CMD_ADDR_LOW) begin
        cmd_addr_low <= reg_wdata;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_ADDR_MID) begin
        cmd_addr_mid <= reg_wdata;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_ADDR_HIGH) begin
        cmd_addr_high <= reg_wdata;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_PORTS_GROUP) begin
        cmd_ports_group <= reg_wdata;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_ATTRIBUTES) begin
        cmd_attributes <= reg_wdata;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_OPCODE) begin
        cmd_opcode <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // operand fields
  // ----------------------------------------
  logic [47:0] op_mac;
  logic [3:0] op_group;
  logic [5:0] op_ports;
  logic [8:0] op_attr;
  logic op_static;
  logic [2:0] op_cmd;
  logic [3:0] op_acc;

  assign op_mac = {cmd_addr_high, cmd_addr_mid, cmd_addr_low}; // [RQ2]
  assign op_group = cmd_ports_group[addr_table_pkg::GROUP_HI:0]; // [RQ1]
  assign op_ports = cmd_ports_group[addr_table_pkg::PMAP_HI:addr_table_pkg::PMAP_LO]; // [RQ1]
  assign op_attr = cmd_attributes[addr_table_pkg::ATTR_HI:0]; // [RQ1]
  assign op_static = cmd_attributes[addr_table_pkg::STATIC_BIT]; // [RQ1]
  assign op_cmd = cmd_opcode[addr_table_pkg::CMD_HI:addr_table_pkg::CMD_LO]; // [RQ1]
  assign op_acc = cmd_opcode[addr_table_pkg::ACC_HI:addr_table_pkg::ACC_LO]; // [RQ1]

  // xor fold of the address picks the hash location
  function automatic logic [5:0] hash_of(input logic [47:0] mac);
    logic [5:0] h;
    h = 6'h00;
    for (int k = 0; k < 8; k++) begin
      h = h ^ mac[k*6 +: 6];
    end
    return h;
  endfunction

  logic [5:0] op_hash;
  assign op_hash = hash_of(op_mac);

  // ----------------------------------------
  // table storage
  // ----------------------------------------
  logic [47:0] tbl_mac [addr_table_pkg::ENTRIES];
  logic [3:0] tbl_group [addr_table_pkg::ENTRIES];
  logic [5:0] tbl_ports [addr_table_pkg::ENTRIES];
  logic [8:0] tbl_attr [addr_table_pkg::ENTRIES];
  logic [addr_table_pkg::ENTRIES-1:0] tbl_static;
  logic [addr_table_pkg::ENTRIES-1:0] tbl_occ;
  logic [addr_table_pkg::ENTRIES-1:0] tbl_bad;

  // ----------------------------------------
  // way inspection at the hash location
  // ----------------------------------------
  logic [addr_table_pkg::WAYS-1:0] way_hit;
  logic [addr_table_pkg::WAYS-1:0] way_free;
  logic [addr_table_pkg::WAYS-1:0] way_dyn;

  for (genvar w = 0; w < addr_table_pkg::WAYS; w++) begin : g_way // [RQ14]
    logic [7:0] wi;
    assign wi = {op_hash, 2'(w)};
    assign way_hit[w] = tbl_occ[wi] && tbl_mac[wi] == op_mac && tbl_group[wi] == op_group;
    assign way_free[w] = !tbl_occ[wi];
    assign way_dyn[w] = !tbl_static[wi];
  end

  logic hit_any;
  logic [1:0] hit_way;
  logic place_any;
  logic [1:0] place_way;

  always_comb begin
    hit_any = 1'b0;
    hit_way = 2'h0;
    place_any = 1'b0;
    place_way = 2'h0;
    for (int w = addr_table_pkg::WAYS - 1; w >= 0; w--) begin
      if (way_hit[w]) begin
        hit_any = 1'b1;
        hit_way = 2'(w);
      end
    end
    // prefer an empty way, else displace a dynamic one; statics are never displaced
    for (int w = addr_table_pkg::WAYS - 1; w >= 0; w--) begin
      if (way_dyn[w]) begin
        place_any = 1'b1;
        place_way = 2'(w);
      end
    end
    for (int w = addr_table_pkg::WAYS - 1; w >= 0; w--) begin
      if (way_free[w]) begin
        place_any = 1'b1;
        place_way = 2'(w);
      end
    end
  end

  // ----------------------------------------
  // scan match for the entry under the cursor
  // ----------------------------------------
  logic [7:0] cursor;
  logic scan_hit;

  always_comb begin
    if (op_acc == addr_table_pkg::ACC_EMPTY) begin
      scan_hit = !tbl_occ[cursor]; // [RQ5]
    end else begin
      // access bit 2 = address, bit 1 = group, bit 0 = port
      scan_hit = tbl_occ[cursor]
        && (!op_acc[2] || tbl_mac[cursor] == op_mac)
        && (!op_acc[1] || tbl_group[cursor] == op_group)
        && (!op_acc[0] || (tbl_ports[cursor] & op_ports) != 6'h00); // [RQ6] [RQ7]
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic is_create;
  logic is_overwrite;
  logic is_erase;
  logic is_search;
  logic is_ptr_addr;
  logic is_ptr_first;

  assign is_create = op_cmd == addr_table_pkg::CMD_WRITE && op_acc == addr_table_pkg::ACC_CREATE;
  assign is_overwrite = op_cmd == addr_table_pkg::CMD_WRITE && op_acc == addr_table_pkg::ACC_EXACT;
  assign is_erase = op_cmd == addr_table_pkg::CMD_ERASE && op_acc == addr_table_pkg::ACC_EXACT;
  assign is_search = op_cmd == addr_table_pkg::CMD_SEARCH
    && (op_acc == addr_table_pkg::ACC_EMPTY || (op_acc[3] && op_acc[2:0] != 3'h0));
  assign is_ptr_addr = op_cmd == addr_table_pkg::CMD_POINTER
    && op_acc == addr_table_pkg::ACC_BY_ADDR;
  assign is_ptr_first = op_cmd == addr_table_pkg::CMD_POINTER
    && op_acc == addr_table_pkg::ACC_FIRST;

  // ----------------------------------------
  // engine sequencing and results
  // ----------------------------------------
  logic [7:0] ptr;
  logic ptr_fresh;
  logic [2:0] res_code;
  logic [47:0] res_mac;
  logic [3:0] res_group;
  logic [5:0] res_ports;
  logic [8:0] res_attr;
  logic res_static;
  logic res_occ;
  logic res_bad;
  logic tbl_we;
  logic tbl_clear;
  logic [7:0] tbl_widx;

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= addr_table_pkg::st_idle;
      cursor <= addr_table_pkg::FIRST_IDX;
      ptr <= addr_table_pkg::FIRST_IDX;
      ptr_fresh <= 1'b1;
      res_code <= addr_table_pkg::RES_OK;
    end else begin
      case (state)
        addr_table_pkg::st_idle: begin
          if (launch) begin
            state <= addr_table_pkg::st_exec; // [RQ24]
          end
        end
        addr_table_pkg::st_exec: begin
          state <= addr_table_pkg::st_idle;
          if (is_create) begin
            res_code <= (hit_any || place_any) ? addr_table_pkg::RES_OK
              : addr_table_pkg::RES_FULL; // [RQ13]
          end else if (is_overwrite || is_erase) begin
            res_code <= hit_any ? addr_table_pkg::RES_OK : addr_table_pkg::RES_NOT_FOUND; // [RQ23]
          end else if (is_ptr_addr) begin
            ptr <= {op_hash, 2'h0}; // [RQ8]
            ptr_fresh <= 1'b1;
            res_code <= addr_table_pkg::RES_OK;
          end else if (is_ptr_first) begin
            ptr <= addr_table_pkg::FIRST_IDX; // [RQ9]
            ptr_fresh <= 1'b1;
            res_code <= addr_table_pkg::RES_OK;
          end else if (is_search) begin
            // resume just past the last match so repeated searches make progress
            if (!ptr_fresh && ptr == addr_table_pkg::LAST_IDX) begin
              res_code <= addr_table_pkg::RES_NOT_FOUND; // [RQ23]
            end else begin
              cursor <= ptr_fresh ? ptr : ptr + 8'h01; // [RQ20]
              state <= addr_table_pkg::st_scan;
            end
          end else begin
            res_code <= addr_table_pkg::RES_CMD_ERROR; // [RQ25] [RQ12]
          end
        end
        addr_table_pkg::st_scan: begin
          if (scan_hit) begin
            ptr <= cursor; // [RQ20]
            ptr_fresh <= 1'b0;
            res_code <= addr_table_pkg::RES_OK; // [RQ12]
            state <= addr_table_pkg::st_idle;
          end else if (cursor == addr_table_pkg::LAST_IDX) begin
            res_code <= addr_table_pkg::RES_NOT_FOUND; // [RQ23]
            state <= addr_table_pkg::st_idle;
          end else begin
            cursor <= cursor + 8'h01; // [RQ20]
          end
        end
        default: begin
          state <= addr_table_pkg::st_idle;
        end
      endcase
    end
  end

  // returned entry fields are captured on the same edge that drops busy
  always_ff @(posedge clk) begin
    if (reset) begin
      res_mac <= 48'h000000000000;
      res_group <= 4'h0;
      res_ports <= 6'h00;
      res_attr <= 9'h000;
      res_static <= 1'b0;
      res_occ <= 1'b0;
      res_bad <= 1'b0;
    end else if (state == addr_table_pkg::st_scan && scan_hit) begin
      res_mac <= tbl_mac[cursor]; // [RQ10]
      res_group <= tbl_group[cursor];
      res_ports <= tbl_ports[cursor];
      res_attr <= tbl_attr[cursor];
      res_static <= tbl_static[cursor];
      res_occ <= tbl_occ[cursor];
      res_bad <= tbl_bad[cursor];
    end
  end

  // ----------------------------------------
  // table write port
  // ----------------------------------------
  always_comb begin
    tbl_we = 1'b0;
    tbl_clear = 1'b0;
    tbl_widx = {op_hash, hit_way};
    if (state == addr_table_pkg::st_exec) begin
      if (is_create) begin
        tbl_we = hit_any || place_any; // [RQ3]
        tbl_widx = hit_any ? {op_hash, hit_way} : {op_hash, place_way};
      end else if (is_overwrite) begin
        tbl_we = hit_any; // [RQ3]
      end else if (is_erase) begin
        tbl_we = hit_any; // [RQ4]
        tbl_clear = 1'b1;
      end
    end
  end

  // the static bit is stored as given; no ageing here ever touches a static entry
  always_ff @(posedge clk) begin
    if (tbl_we && !tbl_clear) begin
      tbl_mac[tbl_widx] <= op_mac;
      tbl_group[tbl_widx] <= op_group;
      tbl_ports[tbl_widx] <= op_ports;
      tbl_attr[tbl_widx] <= op_attr; // [RQ22]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tbl_occ <= '0;
      tbl_static <= '0;
      tbl_bad <= '0;
    end else if (tbl_we) begin
      tbl_occ[tbl_widx] <= !tbl_clear; // [RQ4]
      tbl_static[tbl_widx] <= op_static && !tbl_clear; // [RQ22]
      tbl_bad[tbl_widx] <= 1'b0;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  assign engine_busy = state != addr_table_pkg::st_idle; // [RQ15]

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= addr_table_pkg::WORD_RESET;
    end else if (reg_rd) begin
      if (reg_addr == addr_table_pkg::OFS_CMD_ADDR_LOW) begin
        reg_rdata <= cmd_addr_low;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_ADDR_MID) begin
        reg_rdata <= cmd_addr_mid;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_ADDR_HIGH) begin
        reg_rdata <= cmd_addr_high;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_PORTS_GROUP) begin
        reg_rdata <= cmd_ports_group;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_ATTRIBUTES) begin
        reg_rdata <= cmd_attributes;
      end else if (reg_addr == addr_table_pkg::OFS_CMD_OPCODE) begin
        reg_rdata <= cmd_opcode;
      end else if (reg_addr == addr_table_pkg::OFS_RES_ADDR_LOW) begin
        reg_rdata <= res_mac[15:0]; // [RQ10]
      end else if (reg_addr == addr_table_pkg::OFS_RES_ADDR_MID) begin
        reg_rdata <= res_mac[31:16];
      end else if (reg_addr == addr_table_pkg::OFS_RES_ADDR_HIGH) begin
        reg_rdata <= res_mac[47:32];
      end else if (reg_addr == addr_table_pkg::OFS_RES_PORTS_GROUP) begin
        reg_rdata <= {6'h00, res_ports, res_group};
      end else if (reg_addr == addr_table_pkg::OFS_RES_ATTRIBUTES) begin
        reg_rdata <= {7'h00, res_attr};
      end else if (reg_addr == addr_table_pkg::OFS_RES_OUTCOME) begin
        reg_rdata <= {engine_busy, res_code, 9'h000, res_bad, res_occ, res_static}; // [RQ15]
      end else begin
        reg_rdata <= addr_table_pkg::WORD_RESET;
      end
    end else begin
      reg_rdata <= addr_table_pkg::WORD_RESET;
    end
  end

endmodule

// file: tb/host_model.sv
// host-side model: drives the table registers the way software would
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic [9:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  logic timed_out;
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    timed_out = 1'b0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // released lines are inverted so a stale value never passes for a held one
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // ----------------------------------------
  // command sequence
  // ----------------------------------------
  // polls the busy bit of the outcome word, bounded so a hang is reported
  task automatic wait_idle();
    logic [15:0] d;
    int n;
    n = 0;
    do begin
      rd(addr_table_pkg::OFS_RES_OUTCOME, d);
      n++;
    end while (d[15] !== 1'b0 && n < 400);
    if (d[15] !== 1'b0) timed_out = 1'b1;
  endtask
  task automatic cmd(input logic [47:0] a, input logic [15:0] pg, at, op);
    wait_idle();
    wr(addr_table_pkg::OFS_CMD_ADDR_LOW, a[15:0]);
    wr(addr_table_pkg::OFS_CMD_ADDR_MID, a[31:16]);
    wr(addr_table_pkg::OFS_CMD_ADDR_HIGH, a[47:32]);
    wr(addr_table_pkg::OFS_CMD_PORTS_GROUP, pg);
    wr(addr_table_pkg::OFS_CMD_ATTRIBUTES, at);
    wr(addr_table_pkg::OFS_CMD_OPCODE, op);
    wait_idle();
  endtask
endmodule

// file: tb/address_table_access_engine_chk.sv
// port checker for the address table access engine
`timescale 1ns/1ps
module table_engine_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic engine_busy
);
  localparam logic [9:0] OP = addr_table_pkg::OFS_CMD_OPCODE;
  localparam logic [9:0] OC = addr_table_pkg::OFS_RES_OUTCOME;
  localparam logic [2:0] CS = addr_table_pkg::CMD_SEARCH;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // engine timing
  // ----------------------------------------
  property p_launch;
    reg_wr && reg_addr == OP && !engine_busy |=> engine_busy;
  endproperty
  a_launch: assert property (p_launch) else $error("busy missing after launch");
  property p_quiet;
    !engine_busy && !(reg_wr && reg_addr == OP) |=> !engine_busy;
  endproperty
  a_quiet: assert property (p_quiet) else $error("busy rose without launch");
  property p_short;
    reg_wr && reg_addr == OP && !engine_busy && reg_wdata[6:4] != CS
      |=> engine_busy ##1 !engine_busy;
  endproperty
  a_short: assert property (p_short) else $error("short command length wrong");
  // a search may need the exec cycle plus one cycle per entry
  property p_search;
    reg_wr && reg_addr == OP && !engine_busy && reg_wdata[6:4] == CS
      |=> engine_busy ##[1:257] !engine_busy;
  endproperty
  a_search: assert property (p_search) else $error("search did not end");
  // ----------------------------------------
  // register reads
  // ----------------------------------------
  property p_busy_bit;
    reg_rd && reg_addr == OC |=> reg_rdata[15] == $past(engine_busy);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");
  property p_code;
    reg_rd && reg_addr == OC && !engine_busy |=> reg_rdata[14:12] inside {3'h0, 3'h1, 3'h2, 3'h5};
  endproperty
  a_code: assert property (p_code) else $error("result code undefined");
  property p_back;
    reg_wr && reg_addr inside {[10'h11A:10'h11F]} && !engine_busy ##1 !reg_wr
      ##1 reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_back: assert property (p_back) else $error("control word readback wrong");
  property p_stands;
    reg_rdata != 16'h0000 |-> $past(reg_rd);
  endproperty
  a_stands: assert property (p_stands) else $error("read data outside its cycle");
endmodule
bind address_table_access_engine table_engine_chk u_chk (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .engine_busy(engine_busy));

// file: tb/tb.sv
// self-checking bench for the address table access engine
`timescale 1ns/1ps
module tb;
  localparam logic [9:0] C0 = addr_table_pkg::OFS_CMD_ADDR_LOW;
  localparam logic [9:0] C5 = addr_table_pkg::OFS_CMD_OPCODE;
  localparam logic [9:0] R0 = addr_table_pkg::OFS_RES_ADDR_LOW;
  localparam logic [9:0] R5 = addr_table_pkg::OFS_RES_OUTCOME;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic engine_busy;
  int n_fail = 0;
  int check_count = 0;
  logic [47:0] ea = 48'h0012_3456_789A;
  logic [47:0] fa [5];
  logic [15:0] d;
  logic [15:0] v;
  logic [3:0] codes [7] = '{4'h9, 4'hA, 4'hC, 4'hE, 4'hD, 4'hB, 4'hF};
  logic [15:0] bad [4] = '{16'h0006, 16'h0011, 16'h0070, 16'h0025};
  always #25 clk = ~clk;
  address_table_access_engine uut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .engine_busy(engine_busy));
  host_model h (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (h.timed_out) n_fail++;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hash of the bench: xor of the eight six-bit slices
  function automatic logic [5:0] hsh(input logic [47:0] a);
    hsh = 6'h00;
    for (int i = 0; i < 8; i++) hsh ^= a[i*6 +: 6];
  endfunction
  task automatic run(input logic [47:0] a, input logic [15:0] pg, at, op, input logic [2:0] r);
    h.cmd(a, pg, at, op);
    if (h.timed_out) finish_test();
    h.rd(R5, d);
    chk("result code", {13'h0, d[14:12]}, {13'h0, r});
  endtask
  task automatic ent(input logic [47:0] a, input logic [15:0] pg, at, oc);
    logic [15:0] w [6];
    w = '{a[15:0], a[31:16], a[47:32], pg, at, oc};
    for (int i = 0; i < 6; i++) begin
      h.rd(R0 + 10'(i), d);
      chk("result word", d, w[i]);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    v = 16'($urandom(41));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      h.rd(C0 + 10'(i), d);
      chk("reset word", d, 16'h0000);
    end
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom);
      h.wr(C0 + 10'(i), v);
      h.rd(C0 + 10'(i), d);
      chk("control word", d, v);
      h.wr(R0 + 10'(i), v);
      h.rd(R0 + 10'(i), d);
      chk("status word", d, 16'h0000);
    end
    h.rd(10'h3FF, d);
    chk("unmapped word", d, 16'h0000);
    $display("test registers done");
    run(ea, 16'h0082, 16'h1155, 16'h0007, 3'h0);
    fa[0] = {16'($urandom), 32'($urandom)};
    if (hsh(fa[0]) == hsh(ea)) fa[0][0] = ~fa[0][0];
    for (int k = 1; k < 5; k++) fa[k] = fa[0] ^ 48'(k * 65);
    for (int k = 0; k < 5; k++) begin
      run(fa[k], 16'h001F, 16'h1000, 16'h0007, k < 4 ? 3'h0 : 3'h1);
    end
    run(fa[1], 16'h001F, 16'h0000, 16'h001F, 3'h0);
    run(fa[4], 16'h001F, 16'h1000, 16'h0007, 3'h0);
    $display("test create done");
    for (int i = 0; i < 7; i++) begin
      run(48'h0, 16'h0000, 16'h0000, 16'h0030, 3'h0);
      run(ea, 16'h0082, 16'h0000, {9'h0, 3'h2, codes[i]}, 3'h0);
      ent(ea, 16'h0082, 16'h0155, 16'h0003);
      run(ea, 16'h0082, 16'h0000, {9'h0, 3'h2, codes[i]}, 3'h2);
    end
    run(fa[0], 16'h0000, 16'h0000, 16'h0034, 3'h0);
    run(ea, 16'h0082, 16'h0000, 16'h002C, hsh(fa[0]) < hsh(ea) ? 3'h0 : 3'h2);
    run(48'h0, 16'h0000, 16'h0000, 16'h0030, 3'h0);
    run(48'h0, 16'h0000, 16'h0000, 16'h0020, 3'h0);
    h.rd(R5, d);
    chk("occupy flag", {15'h0, d[1]}, 16'h0000);
    $display("test search done");
    run(ea, 16'h0102, 16'h1155, 16'h000F, 3'h0);
    run(48'h0, 16'h0000, 16'h0000, 16'h0030, 3'h0);
    run(ea, 16'h0102, 16'h0000, 16'h002C, 3'h0);
    ent(ea, 16'h0102, 16'h0155, 16'h0003);
    run(ea, 16'h0102, 16'h0000, 16'h001F, 3'h0);
    for (int i = 0; i < 4; i++) run(ea, 16'h0102, 16'h1000, bad[i], 3'h5);
    // overwriting an absent entry must not create it; the search below proves that
    run(ea, 16'h0102, 16'h1000, 16'h000F, 3'h2);
    run(48'h0, 16'h0000, 16'h0000, 16'h0030, 3'h0);
    run(ea, 16'h0102, 16'h0000, 16'h002C, 3'h2);
    $display("test modify done");
    // a group search that matches nothing keeps the engine busy for the whole scan
    run(48'h0, 16'h0000, 16'h0000, 16'h0030, 3'h0);
    h.wr(C5, 16'h002A);
    h.wr(C0, 16'hBEEF);
    h.wr(C5, 16'h0030);
    h.wait_idle();
    if (h.timed_out) finish_test();
    h.rd(C0, d);
    chk("operand while busy", d, 16'h0000);
    h.rd(C5, d);
    chk("command while busy", d, 16'h002A);
    h.rd(R5, d);
    chk("scan result", {13'h0, d[14:12]}, 16'h0002);
    $display("test busy done");
    finish_test();
  end
endmodule
